// file: common/plm_pkg.sv
// shared constants, types and decode helpers for the programmable logic macrocell
package plm_pkg;

   // ****************************************************************
   // sizes
   // ****************************************************************
   localparam int PLM_N_IN = 8;                // dedicated input pins
   localparam int PLM_N_PT = 8;                // product terms per cell

   // ****************************************************************
   // register byte offsets
   // ****************************************************************
   localparam logic [7:0] PLM_A_CFG    = 8'h00;   // cell configuration
   localparam logic [7:0] PLM_A_SPLIT  = 8'h04;   // term distribution
   localparam logic [7:0] PLM_A_OESTEP = 8'h08;   // per-step output enables
   localparam logic [7:0] PLM_A_STATUS = 8'h0C;   // live cell state
   localparam logic [7:0] PLM_A_PT0    = 8'h20;   // first term mask

   // ****************************************************************
   // configuration field positions
   // ****************************************************************
   localparam int PLM_CFG_MODE = 0;            // 3-bit output/feedback mode
   localparam int PLM_CFG_FF   = 3;            // 2-bit flip-flop type
   localparam int PLM_CFG_INV  = 5;            // invert primary sum
   localparam int PLM_CFG_CINT = 6;            // clock from buffered signal
   localparam int PLM_CFG_CFAL = 7;            // buffered clock falling edge
   localparam int PLM_CFG_SPD  = 8;            // speed_mode_bit
   localparam int PLM_CFG_SEQ  = 9;            // microcoded output enables
   localparam int PLM_CFG_OE   = 10;           // static output enable
   localparam int PLM_CFG_DUAL = 11;           // dual feedback
   localparam int PLM_CFG_CSEL = 12;           // 4-bit clock source column
   localparam int PLM_CFG_RUN  = 16;           // cell running

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [31:0] PLM_CFG_RST    = 32'h0000_0400;
   localparam logic [7:0]  PLM_SPLIT_RST  = 8'h00;
   localparam logic [7:0]  PLM_OESTEP_RST = 8'hFF;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int PLM_CLK_NS  = 50;            // mclk period
   localparam int PLM_PROP_NS = 100;           // array settle time after a transition
   localparam int PLM_PROP_CYC = (PLM_PROP_NS + PLM_CLK_NS - 1) / PLM_CLK_NS;

   // ****************************************************************
   // modes
   // ****************************************************************
   typedef enum logic [6:0] {
      PLM_OM_COMB     = 7'b000_0001,           // comb out, comb feedback
      PLM_OM_REG      = 7'b000_0010,           // reg out, reg feedback
      PLM_OM_INPUT    = 7'b000_0100,           // pin is an input only
      PLM_OM_COMB_FBC = 7'b000_1000,           // comb out, comb feedback
      PLM_OM_REG_FBR  = 7'b001_0000,           // reg out, reg feedback
      PLM_OM_COMB_FBR = 7'b010_0000,           // comb out, reg feedback
      PLM_OM_REG_FBC  = 7'b100_0000            // reg out, comb feedback
   } plm_om_e;

   typedef enum logic [3:0] {
      PLM_FF_D  = 4'b0001,
      PLM_FF_JK = 4'b0010,
      PLM_FF_T  = 4'b0100,
      PLM_FF_SR = 4'b1000
   } plm_ff_e;

   // mode code to one-hot; code 7 is illegal and falls back to comb
   function automatic plm_om_e plm_om_dec(input logic [2:0] c);
      unique case (c)
         3'h1:    return PLM_OM_REG;
         3'h2:    return PLM_OM_INPUT;
         3'h3:    return PLM_OM_COMB_FBC;
         3'h4:    return PLM_OM_REG_FBR;
         3'h5:    return PLM_OM_COMB_FBR;
         3'h6:    return PLM_OM_REG_FBC;
         default: return PLM_OM_COMB;
      endcase
   endfunction

   function automatic plm_ff_e plm_ff_dec(input logic [1:0] c);
      unique case (c)
         2'h0: return PLM_FF_D;
         2'h1: return PLM_FF_JK;
         2'h2: return PLM_FF_T;
         2'h3: return PLM_FF_SR;
      endcase
   endfunction

endpackage

// file: common/plm_arr_if.sv
// carrier between the cell logic and its product-term array
`timescale 1ns/100ps
interface plm_arr_if #(
   parameter int NA   = 10,
   parameter int N_PT = 8
);
   logic [NA-1:0]                 lit;     // array input columns
   logic [N_PT-1:0][2*NA-1:0]     mask;    // {complement, true} connections
   logic [N_PT-1:0]               term;    // product-term results

   modport core  (output lit, output mask, input term);
   modport array (input lit, input mask, output term);
endinterface

// file: src/plm_pterm_array.sv
// programmable and-array: one product term per mask word
`timescale 1ns/100ps
module plm_pterm_array #(
   parameter int NA   = 10,
   parameter int N_PT = 8
)(
   plm_arr_if.array arr                   // columns in, terms out
);

   // a kept connection pulls the term low when its literal is one;
   // an opened one is a no-connect, so both opened means don't-care
   function automatic logic pterm(input logic [NA-1:0]   lit,
                                  input logic [2*NA-1:0] m);
      logic [NA-1:0] kill;
      kill = (m[NA-1:0] & lit) | (m[2*NA-1:NA] & ~lit);
      return ~|kill;
   endfunction

   // ****************************************************************
   // term evaluation
   // ****************************************************************
   genvar g;
   generate
      for (g = 0; g < N_PT; g++) begin : g_pt
         assign arr.term[g] = pterm(arr.lit, arr.mask[g]);
      end
   endgenerate

endmodule

// file: src/plm_macrocell.sv
// programmable logic macrocell with apb configuration
`timescale 1ns/100ps
module plm_macrocell import plm_pkg::*; #(
   parameter int N_IN     = PLM_N_IN,       // dedicated inputs, at most 13
   parameter int N_PT     = PLM_N_PT,       // product terms
   parameter int PROP_CYC = PLM_PROP_CYC    // array settle cycles
)(
   input  wire logic             mclk,      // system clock, 20 MHz
   input  wire logic             rst_n,     // async reset
   input  wire logic             psel,      // apb select
   input  wire logic             penable,   // apb access phase
   input  wire logic             pwrite,    // apb write
   input  wire logic [7:0]       paddr,     // apb byte address
   input  wire logic [31:0]      pwdata,    // apb write data
   output logic      [31:0]      prdata,    // apb read data
   output logic                  pready,    // apb ready
   output logic                  pslverr,   // apb error, unmapped
   input  wire logic [N_IN-1:0]  in_pin,    // dedicated input pins
   input  wire logic             io_in,     // cell pin level
   output logic                  io_out,    // cell pin drive value
   output logic                  io_oe      // cell pin drive enable
);

   localparam int NA = N_IN + 2;            // columns: inputs, feedback, pin
   localparam int MW = 2 * NA;              // mask bits per term
   localparam int PW = $clog2(N_PT);        // term index width
   localparam int CW = $clog2(PROP_CYC + 1);
   localparam logic [CW-1:0] PROP_LD = CW'(PROP_CYC);

   // ****************************************************************
   // state
   // ****************************************************************
   typedef struct packed {
      logic [N_IN-1:0]         in_m;        // input sync, first stage
      logic [N_IN-1:0]         in_s;        // input sync, second stage
      logic                    io_m;        // pin sync, first stage
      logic                    io_s;        // pin sync, second stage
      logic [31:0]             cfg;         // configuration word
      logic [N_PT-1:0]         split;       // term to secondary input
      logic [7:0]              oestep;      // enable per microcode step
      logic [N_PT-1:0][MW-1:0] mask;        // and-array connections
      logic [NA-1:0]           lit_prev;    // delayed columns
      logic [CW-1:0]           pwr_cnt;     // array power hold
      logic                    sum;         // held primary sum
      logic                    sumb;        // held secondary sum
      logic                    q;           // the cell flip-flop
      logic                    clk_prev;    // buffered clock history
      logic [2:0]              step;        // microcode step
      logic                    pready;      // bus ready
      logic                    pslverr;     // bus error
      logic [31:0]             prdata;      // bus read data
      logic                    io_out;      // pin value
      logic                    io_oe;       // pin enable
   } plm_st_s;

   // erased array: every connection kept, so every term is false
   localparam plm_st_s ST_RST = '{cfg: PLM_CFG_RST, split: N_PT'(PLM_SPLIT_RST),
                                  oestep: PLM_OESTEP_RST, mask: '1, default: '0};

   plm_st_s st_q;                           // registered state
   plm_st_s st_d;                           // next state

   // ****************************************************************
   // decode of configuration
   // ****************************************************************
   plm_om_e         om;                     // output/feedback mode
   plm_ff_e         ff;                     // flip-flop type
   logic            run;                    // cell running
   logic            fb_reg;                 // internal feedback from register
   logic            out_reg;                // pin driven from register
   logic            fb_val;                 // internal feedback column
   logic            col_pin;                // pin feedback column
   logic [NA-1:0]   lit;                    // array columns
   logic [N_PT-1:0] term;                   // product terms
   logic            trans;                  // any column changed
   logic            pwr;                    // array powered
   logic            sum_a;                  // primary sum, after inversion
   logic            sum_b;                  // secondary sum
   logic            a_eff;                  // primary input seen by the flop
   logic            b_eff;                  // secondary input seen by the flop
   logic            clk_src;                // buffered clock source
   logic            tick;                   // flip-flop clock event
   logic            acc;                    // apb access phase
   logic            pt_hit;                 // term mask address
   logic [PW-1:0]   pt_idx;                 // term mask index
   logic            hit;                    // mapped address
   logic [31:0]     rd_val;                 // read mux

   assign om     = plm_om_dec(st_q.cfg[PLM_CFG_MODE +: 3]);
   assign ff     = plm_ff_dec(st_q.cfg[PLM_CFG_FF +: 2]);
   assign run    = st_q.cfg[PLM_CFG_RUN];

   // feedback routing per mode
   assign fb_reg  = (om == PLM_OM_REG) || (om == PLM_OM_REG_FBR)
                 || (om == PLM_OM_COMB_FBR);
   assign out_reg = (om == PLM_OM_REG) || (om == PLM_OM_REG_FBR)
                 || (om == PLM_OM_REG_FBC);
   assign fb_val  = fb_reg ? st_q.q : st_q.sum;
   // with dual feedback the pin is an independent input column
   assign col_pin = (st_q.cfg[PLM_CFG_DUAL] || om == PLM_OM_INPUT)
                  ? st_q.io_s : fb_val;
   // feedback reads the held sum, so there is no combinational loop
   assign lit     = {col_pin, fb_val, st_q.in_s};

   // ****************************************************************
   // and-array
   // ****************************************************************
   plm_arr_if #(.NA(NA), .N_PT(N_PT)) arr ();
   assign arr.lit  = lit;
   assign arr.mask = st_q.mask;
   assign term     = arr.term;

   plm_pterm_array #(
      .NA   (NA),
      .N_PT (N_PT)
   ) u_arr (
      .arr  (arr.array)
   );

   // two or-sums share the terms as the split mask distributes them
   assign sum_a = (|(term & ~st_q.split)) ^ st_q.cfg[PLM_CFG_INV];
   assign sum_b = |(term & st_q.split);

   // ****************************************************************
   // transition detection and array power
   // ****************************************************************
   // xor against the delayed columns; powers the array in the same cycle the columns change
   assign trans = |(lit ^ st_q.lit_prev);
   assign pwr   = st_q.cfg[PLM_CFG_SPD] || trans
               || (st_q.pwr_cnt != '0);
   // while powered down the flop sees the last settled sums
   assign a_eff = pwr ? sum_a : st_q.sum;
   assign b_eff = pwr ? sum_b : st_q.sumb;

   // ****************************************************************
   // clocking
   // ****************************************************************
   // the clock buffer may take any column; cells on one column form a group
   assign clk_src = (st_q.cfg[PLM_CFG_CSEL +: 4] < 4'(NA))
                  ? lit[st_q.cfg[PLM_CFG_CSEL +: 4]] : 1'b0;
   assign tick = run && (!st_q.cfg[PLM_CFG_CINT] ||
                 (st_q.cfg[PLM_CFG_CFAL] ? (st_q.clk_prev && !clk_src)
                                         : (!st_q.clk_prev && clk_src)));

   // physical flop is d or toggle; jk and sr add gating around toggle
   function automatic logic next_q(input plm_ff_e t, input logic q,
                                   input logic a, input logic b);
      logic tog;
      tog = 1'b0;
      unique case (t)
         PLM_FF_D:  return a;
         PLM_FF_T:  tog = a;
         PLM_FF_JK: tog = (a && !q) || (b && q);
         PLM_FF_SR: tog = (a && !b && !q) || (b && !a && q);
      endcase
      return q ^ tog;
   endfunction

   // ****************************************************************
   // bus decode
   // ****************************************************************
   assign acc    = psel && penable;
   assign pt_hit = (paddr >= PLM_A_PT0) && (paddr < PLM_A_PT0 + 8'(4 * N_PT))
                && (paddr[1:0] == 2'h0);
   assign pt_idx = paddr[2 +: PW];
   assign hit    = pt_hit || paddr == PLM_A_CFG || paddr == PLM_A_SPLIT
                || paddr == PLM_A_OESTEP || paddr == PLM_A_STATUS;
   assign rd_val = (paddr == PLM_A_CFG)    ? st_q.cfg :
                   (paddr == PLM_A_SPLIT)  ? 32'(st_q.split) :
                   (paddr == PLM_A_OESTEP) ? 32'(st_q.oestep) :
                   (paddr == PLM_A_STATUS) ? 32'({st_q.step, pwr, st_q.io_s,
                                                  st_q.sum, st_q.q}) :
                   pt_hit                  ? 32'(st_q.mask[pt_idx]) : 32'h0000_0000;

   // ****************************************************************
   // next state
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      // two-stage synchronisers on every pin
      st_d.in_m     = in_pin;
      st_d.in_s     = st_q.in_m;
      st_d.io_m     = io_in;
      st_d.io_s     = st_q.io_m;
      st_d.lit_prev = lit;
      st_d.clk_prev = clk_src;
      // power window restarts on each transition
      if (trans) begin
         st_d.pwr_cnt = PROP_LD;
      end else if (st_q.pwr_cnt != '0) begin
         st_d.pwr_cnt = st_q.pwr_cnt - CW'(1);
      end
      // sums only move while the array is powered
      if (pwr) begin
         st_d.sum  = sum_a;
         st_d.sumb = sum_b;
      end
      // flop and microcode step advance on a clock event
      if (tick) begin
         st_d.q = next_q(ff, st_q.q, a_eff, b_eff);
         if (st_q.cfg[PLM_CFG_SEQ]) begin
            st_d.step = st_q.step + 3'h1;
         end
      end
      // pin drive
      st_d.io_out = out_reg ? st_q.q : st_q.sum;
      if (om == PLM_OM_INPUT) begin
         st_d.io_oe = 1'b0;
      end else if (st_q.cfg[PLM_CFG_SEQ]) begin
         st_d.io_oe = st_q.oestep[st_q.step];
      end else begin
         st_d.io_oe = st_q.cfg[PLM_CFG_OE];
      end
      // one wait state: ready rises after the first access cycle
      st_d.pready = acc && !st_q.pready;
      if (acc && !st_q.pready) begin
         st_d.prdata  = rd_val;
         st_d.pslverr = !hit;
      end
      // writes land at the edge where ready is sampled high
      if (acc && st_q.pready && pwrite && hit) begin
         if (paddr == PLM_A_CFG) begin
            if (run) begin
               st_d.cfg[PLM_CFG_RUN] = pwdata[PLM_CFG_RUN];
            end else begin
               st_d.cfg = pwdata;
            end
         end else if (!run) begin
            // array and enables are frozen while running
            if (paddr == PLM_A_SPLIT) begin
               st_d.split = pwdata[N_PT-1:0];
            end else if (paddr == PLM_A_OESTEP) begin
               st_d.oestep = pwdata[7:0];
            end else if (pt_hit) begin
               st_d.mask[pt_idx] = pwdata[MW-1:0];
            end
         end
      end
   end

   // ****************************************************************
   // state register
   // ****************************************************************
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= ST_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata  = st_q.prdata;
   assign pready  = st_q.pready;
   assign pslverr = st_q.pslverr;
   assign io_out  = st_q.io_out;
   assign io_oe   = st_q.io_oe;

   // ****************************************************************
   // checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_apb_one_wait: assert property (acc && !pready |=> pready ##1 !pready)
      else $error("apb ready not one cycle after access");
   a_erased_false: assert property ((&st_q.mask) && !st_q.cfg[PLM_CFG_INV] |-> !sum_a)
      else $error("erased array gave a true sum");
   a_input_no_oe: assert property (om == PLM_OM_INPUT |=> !io_oe)
      else $error("input mode drives the pin");
   a_speed_pwr: assert property (st_q.cfg[PLM_CFG_SPD] |-> pwr)
      else $error("array unpowered in speed mode");
   a_power_down: assert property ((!st_q.cfg[PLM_CFG_SPD] && !trans)[*3] |-> !pwr)
      else $error("array stays powered after settle");
   a_d_capture: assert property (tick && ff == PLM_FF_D |=> st_q.q == $past(a_eff))
      else $error("d capture wrong");
   a_jk_invert: assert property (tick && ff == PLM_FF_JK && a_eff && b_eff
                                 |=> st_q.q != $past(st_q.q))
      else $error("jk both high did not invert");
   a_hold_no_tick: assert property (!tick |=> $stable(st_q.q))
      else $error("flop moved without a clock event");
   a_reg_out: assert property (out_reg |=> io_out == $past(st_q.q))
      else $error("registered output not from flop");
   a_seq_oe: assert property (st_q.cfg[PLM_CFG_SEQ] && om != PLM_OM_INPUT
                              |=> io_oe == $past(st_q.oestep[st_q.step]))
      else $error("step enable not applied");

   // jk gating: both low holds, j alone sets, k alone clears
   a_jk_hold: assert property (tick && ff == PLM_FF_JK && !a_eff && !b_eff
                               |=> $stable(st_q.q))
      else $error("jk both low did not hold");
   a_jk_set: assert property (tick && ff == PLM_FF_JK && a_eff && !b_eff
                              |=> st_q.q)
      else $error("jk set failed");
   a_jk_clear: assert property (tick && ff == PLM_FF_JK && !a_eff && b_eff
                                |=> !st_q.q)
      else $error("jk clear failed");

   // a buffered edge of the chosen polarity always makes a tick
   a_buf_edge: assert property (run && st_q.cfg[PLM_CFG_CINT] &&
                                (st_q.cfg[PLM_CFG_CFAL] ? $fell(clk_src) : $rose(clk_src))
                                |-> tick)
      else $error("buffered clock edge missed");

   // nothing but the run bit may move while the cell runs
   a_cfg_frozen: assert property (run |=> $stable(st_q.mask) && $stable(st_q.split)
                                  && $stable(st_q.oestep) && $stable(st_q.cfg[15:0]))
      else $error("configuration changed while running");

   // static enable reaches the pin one cycle later
   a_static_oe: assert property (!st_q.cfg[PLM_CFG_SEQ] && om != PLM_OM_INPUT
                                 |=> io_oe == $past(st_q.cfg[PLM_CFG_OE]))
      else $error("static enable not applied");

   // powered sums follow the array, unpowered ones hold
   a_speed_sum: assert property (st_q.cfg[PLM_CFG_SPD] |=> st_q.sum == $past(sum_a))
      else $error("sum not following array in speed mode");
   a_sum_held: assert property (!pwr |=> $stable(st_q.sum))
      else $error("sum moved while array unpowered");

   c_jk_toggle: cover property (tick && ff == PLM_FF_JK && a_eff && b_eff);
   c_power_down: cover property (pwr ##1 !pwr);
   c_seq_wrap: cover property (tick && st_q.cfg[PLM_CFG_SEQ] && st_q.step == 3'h7);
   c_apb_write: cover property (acc && pready && pwrite);
   c_fall_tick: cover property (tick && st_q.cfg[PLM_CFG_CINT] && st_q.cfg[PLM_CFG_CFAL]);

endmodule

// file: tb/plm_board.sv
// board-side model: dedicated inputs and the shared cell pin
`timescale 1ns/100ps
module plm_board import plm_pkg::*; (
   input  wire logic                mclk,     // system clock
   input  wire logic [PLM_N_IN-1:0] pins_req, // wanted input levels
   input  wire logic                pin_req,  // board level on a released pin
   input  wire logic                io_out,   // cell drive value
   input  wire logic                io_oe,    // cell drive enable
   output logic      [PLM_N_IN-1:0] in_pin,   // dedicated inputs
   output logic                     io_in     // resolved pin level
);
   // inputs move just after the edge, like clocked board logic
   always_ff @(posedge mclk) in_pin <= pins_req;
   // cell wins while enabled, board drives the pin otherwise
   assign io_in = io_oe ? io_out : pin_req;
endmodule

// file: tb/programmable_logic_macrocell_tb.sv
// self-checking bench for the macrocell
`timescale 1ns/100ps
module programmable_logic_macrocell_tb import plm_pkg::*;;
   logic mclk, rst_n, psel, penable, pwrite, pready, pslverr;
   logic io_in, io_out, io_oe, pin_req, e, q_exp, j, k;
   logic [2:0] s_exp;
   logic [7:0] paddr, pins_req, in_pin;
   logic [31:0] pwdata, prdata, r, m, c;
   int errors, comparisons;
   plm_macrocell plm_macrocell_i (.mclk(mclk), .rst_n(rst_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .in_pin(in_pin),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   plm_board plm_board_i (.mclk(mclk), .pins_req(pins_req), .pin_req(pin_req),
      .io_out(io_out), .io_oe(io_oe), .in_pin(in_pin), .io_in(io_in));
   initial begin
      mclk = 0;
      forever #25 mclk = ~mclk;
   end
   // ****************************************************************
   // tasks
   // ****************************************************************
   task automatic stop_test;
      if (errors == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // apb transfer: hold everything until pready is seen at an edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1;
      do @(posedge mclk); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 0; penable <= 0;
   endtask
   // one term: a kept connection whose literal is one kills it
   function automatic logic pterm(input logic [19:0] k, input logic [9:0] x);
      return &(~(k[9:0] & x) & ~(k[19:10] & ~x));
   endfunction
   // jk next state: hold, clear, set, invert
   function automatic logic jk_next(input logic q, input logic j, input logic k);
      return (j && !q) || (!k && q);
   endfunction
   // output modes that drive the pin from the flop
   function automatic logic reg_out(input logic [2:0] md);
      return md == 3'h1 || md == 3'h4 || md == 3'h6;
   endfunction
   // ****************************************************************
   // tests
   // ****************************************************************
   initial begin
      errors = 0; comparisons = 0;
      rst_n = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
      pins_req = 0; pin_req = 0;
      void'($urandom(29229));
      repeat (16) @(posedge mclk);
      rst_n <= 1;
      apb(0, PLM_A_CFG, 0);    chk(r, PLM_CFG_RST);
      apb(0, PLM_A_SPLIT, 0);  chk(r, {24'h0, PLM_SPLIT_RST});
      apb(0, PLM_A_OESTEP, 0); chk(r, {24'h0, PLM_OESTEP_RST});
      apb(0, 8'h10, 0);        chk({r[30:0], e}, 32'h1);
      // random masks on term 0, every mode code in turn, d flop running
      for (int i = 0; i < 12; i++) begin
         m = (i == 0) ? 32'h0 : ($urandom & $urandom & 32'h0003_FCFF);
         c = 32'h0001_0500 | 32'(i % 8) | (i % 4 == 3 ? 32'h20 : 0)
           | (i % 3 == 0 ? 32'h800 : 0);
         apb(1, PLM_A_CFG, 0);
         apb(1, PLM_A_PT0, m);
         apb(1, PLM_A_CFG, c);
         pins_req <= 8'($urandom);
         repeat (8) @(posedge mclk);
         chk(io_out, pterm(m[19:0], {2'b0, pins_req}) ^ c[5]);
         chk(io_oe, c[2:0] != 3'h2);
         apb(0, PLM_A_STATUS, 0);
         if (reg_out(c[2:0])) chk(r[0], io_out);
      end
      // running: term distribution write is refused
      apb(1, PLM_A_SPLIT, 32'hFF);
      apb(0, PLM_A_SPLIT, 0);  chk(r, 32'h0);
      // input mode: pin released, pin column feeds term 0
      apb(1, PLM_A_CFG, 0);
      apb(1, PLM_A_PT0, 32'h8_0000);
      apb(1, PLM_A_CFG, 32'h0000_0502);
      for (int v = 1; v >= 0; v--) begin
         pin_req <= v[0];
         repeat (8) @(posedge mclk);
         chk(io_oe, 0);
         apb(0, PLM_A_STATUS, 0);
         chk(r[1], v[0]);
      end
      // jk clocked by pin 7 through the buffer, rising then falling edge
      pins_req <= 8'h00;
      m = $urandom & 32'hFF;
      apb(1, PLM_A_PT0, 32'h400);
      apb(1, PLM_A_PT0 + 8'h04, 32'h800);
      apb(1, PLM_A_SPLIT, 32'h2);
      apb(1, PLM_A_OESTEP, m);
      apb(0, PLM_A_STATUS, 0);
      q_exp = r[0];
      s_exp = r[6:4];
      for (int f = 0; f < 2; f++) begin
         apb(1, PLM_A_CFG, 0);
         apb(1, PLM_A_CFG, 32'h0001_7649 | (f ? 32'h0000_0080 : 32'h0000_0000));
         for (int n = 0; n < 8; n++) begin
            {j, k} = 2'($urandom);
            pins_req[1:0] <= {k, j};
            repeat (6) @(posedge mclk);
            pins_req[7] <= 1'b1;
            repeat (6) @(posedge mclk);
            pins_req[7] <= 1'b0;
            repeat (6) @(posedge mclk);
            q_exp = jk_next(q_exp, j, k);
            s_exp = s_exp + 3'h1;
            chk(io_out, q_exp);
            chk(io_oe, m[s_exp]);
         end
      end
      stop_test;
   end
   // watchdog cuts a hang well past the expected run time
   initial begin
      #(50 * 5000);
      errors++;
      stop_test;
   end
endmodule
